//--- core/nsx_pkg.sv
package nsx_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  // ---------------------------------------------------------------
  // direction register operands and reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] DIR_A_ADDR  = 7'h05;
  localparam logic [6:0] DIR_B_ADDR  = 7'h06;
  localparam logic [6:0] DIR_C_ADDR  = 7'h07;
  localparam logic [7:0] DIR_RST     = 8'hFF;
  localparam logic [7:0] ACC_RST     = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic       DEST_ACC    = 1'b0;
  localparam logic       DEST_REG    = 1'b1;
  // ---------------------------------------------------------------
  // operation codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    NSX_OP_NONE,
    NSX_OP_NIBBLE_EXCHANGE,
    NSX_OP_DIRECTION_LOAD,
    NSX_OP_XOR_IMMEDIATE,
    NSX_OP_XOR_REGISTER
  } nsx_op_t;
endpackage

//--- core/nsx_result_unit.sv
`timescale 1ns/1ns
module nsx_result_unit
  import nsx_pkg::*;
(
  input  wire nsx_pkg::nsx_op_t op,
  input  wire logic [7:0]       accIn,
  input  wire logic [7:0]       operand,
  input  wire logic [7:0]       immediate,
  output logic      [7:0]       result,
  output logic                  isZero
);
  import nsx_pkg::*;

  always_comb begin
    case (op)
      NSX_OP_NIBBLE_EXCHANGE: result = {operand[3:0], operand[7:4]};
      NSX_OP_XOR_IMMEDIATE:   result = accIn ^ immediate;
      NSX_OP_XOR_REGISTER:    result = accIn ^ operand;
      NSX_OP_DIRECTION_LOAD:  result = accIn;
      default:                result = BYTE_ZERO;
    endcase
    isZero = (result == BYTE_ZERO);
  end
endmodule

//--- core/nsx_exec.sv
// What this block does
// - The nibble exchange puts the operand low nibble on top and its high nibble below.
// - For the nibble exchange, dest 0 writes the accumulator, dest 1 the register.
// - The direction load takes only operands 5 to 7, copies the accumulator, keeps the flags.
// - Operand 5 loads port A direction, 6 port B direction, 7 port C direction.
// - The immediate XOR combines the accumulator with an 8-bit immediate into the accumulator.
// - The immediate XOR changes only the zero flag, not carry or digit carry.
// - The register XOR combines the accumulator with a register addressed by a 7-bit operand.
// - For the register XOR, dest 0 writes the accumulator and dest 1 writes the register back.
// - The register XOR changes only the zero flag among the status flags.
`timescale 1ns/1ns
module nsx_exec
  import nsx_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             opValid,
  input  wire nsx_pkg::nsx_op_t opCode,
  input  wire logic [6:0]       opAddr,
  input  wire logic             destSel,
  input  wire logic [7:0]       immediate,
  input  wire logic [7:0]       regRdData,
  input  wire logic             carryIn,
  input  wire logic             digitCarryIn,
  output logic      [7:0]       acc,
  output logic                  zeroFlag,
  output logic                  carryFlag,
  output logic                  digitCarryFlag,
  output logic                  regWrEn,
  output logic      [6:0]       regWrAddr,
  output logic      [7:0]       regWrData,
  output logic      [7:0]       portADirection,
  output logic      [7:0]       portBDirection,
  output logic      [7:0]       portCDirection
);
  import nsx_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] acc_r,  acc_nxt;
  logic       zf_r,   zf_nxt;
  logic       cf_r,   cf_nxt;
  logic       dcf_r,  dcf_nxt;
  logic       we_r,   we_nxt;
  logic [6:0] wa_r,   wa_nxt;
  logic [7:0] wd_r,   wd_nxt;
  logic [7:0] dirA_r, dirA_nxt;
  logic [7:0] dirB_r, dirB_nxt;
  logic [7:0] dirC_r, dirC_nxt;

  // ---------------------------------------------------------------
  // result path
  // ---------------------------------------------------------------
  logic [7:0] result;
  logic       isZero;

  nsx_result_unit uResult (
    .op        (opCode),
    .accIn     (acc_r),
    .operand   (regRdData),
    .immediate (immediate),
    .result    (result),
    .isZero    (isZero)
  );

  always_comb begin
    acc_nxt  = acc_r;
    zf_nxt   = zf_r;
    cf_nxt   = carryIn;
    dcf_nxt  = digitCarryIn;
    we_nxt   = 1'b0;
    wa_nxt   = wa_r;
    wd_nxt   = wd_r;
    dirA_nxt = dirA_r;
    dirB_nxt = dirB_r;
    dirC_nxt = dirC_r;
    if (opValid) begin
      case (opCode)
        NSX_OP_NIBBLE_EXCHANGE: begin
          if (destSel == DEST_ACC) begin
            acc_nxt = result;
          end else begin
            we_nxt = 1'b1;
            wa_nxt = opAddr;
            wd_nxt = result;
          end
        end
        NSX_OP_DIRECTION_LOAD: begin
          case (opAddr)
            DIR_A_ADDR: dirA_nxt = result;
            DIR_B_ADDR: dirB_nxt = result;
            DIR_C_ADDR: dirC_nxt = result;
            default: ;
          endcase
        end
        NSX_OP_XOR_IMMEDIATE: begin
          acc_nxt = result;
          zf_nxt  = isZero;
        end
        NSX_OP_XOR_REGISTER: begin
          zf_nxt = isZero;
          if (destSel == DEST_ACC) begin
            acc_nxt = result;
          end else begin
            we_nxt = 1'b1;
            wa_nxt = opAddr;
            wd_nxt = result;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_r  <= ACC_RST;
      zf_r   <= 1'b0;
      cf_r   <= 1'b0;
      dcf_r  <= 1'b0;
      we_r   <= 1'b0;
      wa_r   <= '0;
      wd_r   <= BYTE_ZERO;
      dirA_r <= DIR_RST;
      dirB_r <= DIR_RST;
      dirC_r <= DIR_RST;
    end else begin
      acc_r  <= acc_nxt;
      zf_r   <= zf_nxt;
      cf_r   <= cf_nxt;
      dcf_r  <= dcf_nxt;
      we_r   <= we_nxt;
      wa_r   <= wa_nxt;
      wd_r   <= wd_nxt;
      dirA_r <= dirA_nxt;
      dirB_r <= dirB_nxt;
      dirC_r <= dirC_nxt;
    end
  end

  assign acc            = acc_r;
  assign zeroFlag       = zf_r;
  assign carryFlag      = cf_r;
  assign digitCarryFlag = dcf_r;
  assign regWrEn        = we_r;
  assign regWrAddr      = wa_r;
  assign regWrData      = wd_r;
  assign portADirection = dirA_r;
  assign portBDirection = dirB_r;
  assign portCDirection = dirC_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence swapReq;
    opValid && opCode == NSX_OP_NIBBLE_EXCHANGE;
  endsequence

  sequence xregReq;
    opValid && opCode == NSX_OP_XOR_REGISTER;
  endsequence

  swap_value_a: assert property ((swapReq and (destSel == DEST_REG)) |=>
      regWrData == {$past(regRdData[3:0]), $past(regRdData[7:4])})
    else $error("nibble exchange result wrong");
  swap_dest_a: assert property ((swapReq and (destSel == DEST_ACC)) |=>
      !regWrEn && acc == {$past(regRdData[3:0]), $past(regRdData[7:4])})
    else $error("nibble exchange destination wrong");
  dir_flags_a: assert property (opValid && opCode == NSX_OP_DIRECTION_LOAD |=>
      $stable(zeroFlag) && $stable(acc) && !regWrEn)
    else $error("direction load touched flags");
  dir_refuse_a: assert property (opValid && opCode == NSX_OP_DIRECTION_LOAD
      && (opAddr < DIR_A_ADDR || opAddr > DIR_C_ADDR) |=> $stable(portADirection)
      && $stable(portBDirection) && $stable(portCDirection))
    else $error("direction load outside range took effect");
  dir_decode_a: assert property (opValid && opCode == NSX_OP_DIRECTION_LOAD
      && opAddr == DIR_B_ADDR |=> portBDirection == $past(acc)
      && $stable(portADirection) && $stable(portCDirection))
    else $error("direction decode wrong");
  ximm_value_a: assert property (opValid && opCode == NSX_OP_XOR_IMMEDIATE |=>
      acc == ($past(acc) ^ $past(immediate)) && !regWrEn)
    else $error("immediate xor wrong");
  ximm_flags_a: assert property (opValid && opCode == NSX_OP_XOR_IMMEDIATE |=>
      carryFlag == $past(carryIn) && digitCarryFlag == $past(digitCarryIn))
    else $error("immediate xor changed carry");
  xreg_dest_a: assert property ((xregReq and (destSel == DEST_REG)) |=>
      regWrEn && regWrAddr == $past(opAddr) && $stable(acc))
    else $error("register xor destination wrong");
  xreg_value_a: assert property (xregReq |=>
      (regWrEn ? regWrData : acc) == ($past(acc) ^ $past(regRdData)))
    else $error("register xor value wrong");
  zero_flag_a: assert property (xregReq |=>
      zeroFlag == ((regWrEn ? regWrData : acc) == BYTE_ZERO))
    else $error("zero flag wrong");
  zero_rule_a: assert property (!opValid ##1 1 |-> $stable(zeroFlag))
    else $error("zero flag moved while idle");
endmodule

//--- verif/nsx_regfile_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// register file on the far side
// ---------------------------------------------------------------
module nsx_regfile_model (
  input  wire logic       ref_clk,
  input  wire logic [6:0] rdAddr,
  output logic      [7:0] rdData,
  input  wire logic       wrEn,
  input  wire logic [6:0] wrAddr,
  input  wire logic [7:0] wrData
);
  logic [7:0] mem [128];
  // same-cycle read of the addressed register
  assign rdData = mem[rdAddr];
  always @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
  // preload from the bench
  task automatic poke(input logic [6:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
endmodule

//--- verif/nsx_exec_test.sv
`timescale 1ns/1ns
module nsx_exec_test;
  import nsx_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0, rst = 1'b1, opValid = 1'b0, destSel = 1'b0;
  logic carryIn = 1'b0, digitCarryIn = 1'b0, zeroFlag, carryFlag, digitCarryFlag, regWrEn;
  nsx_op_t opCode = NSX_OP_NONE;
  logic [6:0] opAddr = 7'h00, regWrAddr;
  logic [7:0] immediate = 8'h00, regRdData, acc, regWrData;
  logic [7:0] portADirection, portBDirection, portCDirection;
  int numErrors = 0, testsRun = 0;
  always #50 ref_clk = ~ref_clk;
  nsx_exec DUT (.ref_clk(ref_clk), .rst(rst), .opValid(opValid), .opCode(opCode),
    .opAddr(opAddr), .destSel(destSel), .immediate(immediate), .regRdData(regRdData),
    .carryIn(carryIn), .digitCarryIn(digitCarryIn), .acc(acc), .zeroFlag(zeroFlag),
    .carryFlag(carryFlag), .digitCarryFlag(digitCarryFlag), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .portADirection(portADirection),
    .portBDirection(portBDirection), .portCDirection(portCDirection));
  nsx_regfile_model rf (.ref_clk(ref_clk), .rdAddr(opAddr), .rdData(regRdData),
    .wrEn(regWrEn), .wrAddr(regWrAddr), .wrData(regWrData));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    testsRun++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      numErrors++;
    end
  endtask
  task automatic op(input nsx_op_t c, input logic [6:0] a, input logic d, input logic [7:0] k);
    @(negedge ref_clk);
    opCode = c;
    opAddr = a;
    destSel = d;
    immediate = k;
    opValid = 1'b1;
    @(negedge ref_clk);
    opValid = 1'b0;
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_xorimm;
    carryIn = 1'b1;
    digitCarryIn = 1'b1;
    op(NSX_OP_XOR_IMMEDIATE, 7'h00, 1'b0, 8'hA5);
    chk("acc", 8'hA5, acc);
    chk("zero", 8'h00, 8'(zeroFlag));
    chk("carry", 8'h01, 8'(carryFlag));
    chk("dcarry", 8'h01, 8'(digitCarryFlag));
    op(NSX_OP_XOR_IMMEDIATE, 7'h00, 1'b0, 8'hA5);
    chk("acc", 8'h00, acc);
    chk("zero", 8'h01, 8'(zeroFlag));
  endtask
  task automatic t_swap;
    rf.poke(7'h12, 8'h3C);
    op(NSX_OP_NIBBLE_EXCHANGE, 7'h12, DEST_ACC, 8'h00);
    chk("acc", 8'hC3, acc);
    chk("wrEn", 8'h00, 8'(regWrEn));
    op(NSX_OP_NIBBLE_EXCHANGE, 7'h12, DEST_REG, 8'h00);
    chk("wrEn", 8'h01, 8'(regWrEn));
    chk("wrAddr", 8'h12, 8'(regWrAddr));
    chk("wrData", 8'hC3, regWrData);
  endtask
  task automatic t_xorreg;
    carryIn = 1'b0;
    rf.poke(7'h7F, 8'h3C);
    op(NSX_OP_XOR_REGISTER, 7'h7F, DEST_REG, 8'h00);
    chk("carry", 8'h00, 8'(carryFlag));
    chk("wrData", 8'hFF, regWrData);
    chk("wrAddr", 8'h7F, 8'(regWrAddr));
    chk("acc", 8'hC3, acc);
    chk("zero", 8'h00, 8'(zeroFlag));
    op(NSX_OP_XOR_REGISTER, 7'h12, DEST_ACC, 8'h00);
    chk("acc", 8'h00, acc);
    chk("wrEn", 8'h00, 8'(regWrEn));
    chk("zero", 8'h01, 8'(zeroFlag));
  endtask
  task automatic t_dir;
    logic [6:0] fl [6];
    logic [7:0] ea, eb, ec;
    fl = '{7'h04, 7'h08, 7'h05, 7'h06, 7'h07, 7'h00};
    ea = 8'hFF;
    eb = 8'hFF;
    ec = 8'hFF;
    op(NSX_OP_XOR_IMMEDIATE, 7'h00, 1'b0, 8'h5A);
    op(NSX_OP_NONE, 7'h05, 1'b0, 8'hFF);
    chk("acc", 8'h5A, acc);
    foreach (fl[i]) begin
      op(NSX_OP_DIRECTION_LOAD, fl[i], 1'b0, 8'h00);
      if (fl[i] == 7'h05) ea = 8'h5A;
      if (fl[i] == 7'h06) eb = 8'h5A;
      if (fl[i] == 7'h07) ec = 8'h5A;
      chk("dirA", ea, portADirection);
      chk("dirB", eb, portBDirection);
      chk("dirC", ec, portCDirection);
      chk("zero", 8'h00, 8'(zeroFlag));
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    t_xorimm();
    t_swap();
    t_xorreg();
    t_dir();
    close_out();
  end
  initial begin
    #200000;
    numErrors++;
    close_out();
  end
endmodule
